/* verilog/addr_repeat_pkg.sv */
// Constants, encodings and types of the operand address and repeat unit.
// Assumes one core clock and a plain register port with one-cycle reads.
//
// How it works
// RULE1 - Direct address joins page pointer and offset.
// RULE2 - Indirect address comes from the selected register.
// RULE3 - Select pointer value picks register zero to seven.
// RULE4 - Seven indirect update variants are offered.
// RULE5 - Pointer update follows access, same cycle.
// RULE6 - Short immediate is a field of the word.
// RULE7 - Long immediate is the second instruction word.
// RULE8 - Register mode names a core register, no address.
// RULE9 - Repeat count from memory or short field.
// RULE10 - Count N gives N plus one executions.
// RULE11 - Reset clears the repeat counter.
// RULE12 - Interrupts are held off during a repeat.
// RULE13 - Repeated multicycle instructions issue every cycle.
// RULE14 - Repeated table read reads every cycle.
// RULE15 - Next word is fetched during execution.
// RULE16 - External operand access stretches the instruction; the code does not stretch issues under a repeat.
// RULE17 - Add takes one or two words by operand.
// RULE18 - Bit-reversed add carries from the top bit.

package addr_repeat_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int PAGE_W = 9;
	localparam int OFFS_W = 7;
	localparam int AUX_N  = 8;
	localparam int ARP_W  = 3;
	localparam int SIMM_W = 8;
	localparam int RADR_W = 4;
	localparam int WAIT_W = 4;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int OFFS_MSB     = 6;
	localparam int UPD_MSB      = 6;
	localparam int UPD_LSB      = 4;
	localparam int ARP_LOAD_BIT = 3;
	localparam int NEW_ARP_MSB  = 2;
	localparam int SIMM_MSB     = 7;
	localparam int REG_MSB      = 2;

	// ----------------------------------------------------------------
	// Addressing mode codes on the instruction port
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_DIRECT   = 3'h0;
	localparam logic [2:0] MODE_INDIRECT = 3'h1;
	localparam logic [2:0] MODE_SHORT    = 3'h2;
	localparam logic [2:0] MODE_LONG     = 3'h3;
	localparam logic [2:0] MODE_REG      = 3'h4;
	localparam logic [2:0] MODE_IMPLIED  = 3'h5;

	// ----------------------------------------------------------------
	// Indirect update codes
	// ----------------------------------------------------------------
	localparam logic [2:0] UPD_NONE  = 3'h0;
	localparam logic [2:0] UPD_INC   = 3'h1;
	localparam logic [2:0] UPD_DEC   = 3'h2;
	localparam logic [2:0] UPD_ADD0  = 3'h3;
	localparam logic [2:0] UPD_SUB0  = 3'h4;
	localparam logic [2:0] UPD_BRINC = 3'h5;
	localparam logic [2:0] UPD_BRDEC = 3'h6;

	// ----------------------------------------------------------------
	// Register port offsets and status bits
	// ----------------------------------------------------------------
	localparam logic [RADR_W-1:0] REG_PAGE   = 4'h0;
	localparam logic [RADR_W-1:0] REG_ARP    = 4'h1;
	localparam logic [RADR_W-1:0] REG_REPEAT_COUNTER   = 4'h2;
	localparam logic [RADR_W-1:0] REG_STATUS = 4'h3;
	localparam int                AUX_BIT    = 3;
	localparam int ST_ARMED  = 0;
	localparam int ST_HOLD   = 1;
	localparam int ST_REPT   = 2;
	localparam int ST_BUSY   = 3;
	localparam int ST_BITS   = 4;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
	localparam logic [ARP_W-1:0]  ARP_RST  = 3'h0;
	localparam logic [DATA_W-1:0] AUX_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] REPEAT_COUNTER_RST = 16'h0000;
	localparam int TABLE_CYCLES = 3;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LONG,
		S_RPTLD,
		S_BUSY,
		S_REPEAT
	} state_type;

endpackage

/* verilog/aux_update.sv */
// Next value of the current auxiliary register for one indirect access.
// Assumes the caller applies the result after the operand has been used.

`timescale 1ns/1ns
`default_nettype none

module aux_update
	import addr_repeat_pkg::*;
(
	input  wire logic [DATA_W-1:0] aux_val,
	input  wire logic [DATA_W-1:0] index_val,
	input  wire logic [2:0]        code,
	output logic      [DATA_W-1:0] next_val
);

	// ----------------------------------------------------------------
	// Bit mirror
	// ----------------------------------------------------------------

	// Mirroring both sides turns a normal carry chain into one that runs
	// from the top bit down, which is what FFT address order needs.
	function automatic logic [DATA_W-1:0] mirror(input logic [DATA_W-1:0] v);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < DATA_W; i++) begin
			m[i] = v[DATA_W-1-i];
		end
		return m;
	endfunction

	wire [DATA_W-1:0] br_add = mirror(mirror(aux_val) + mirror(index_val));
	wire [DATA_W-1:0] br_sub = mirror(mirror(aux_val) - mirror(index_val));

	// Selection of the update variant; unused code leaves the value alone.
	always_comb begin
		case (code)
			UPD_INC:   next_val = aux_val + 16'h0001; // RULE4
			UPD_DEC:   next_val = aux_val - 16'h0001; // RULE4
			UPD_ADD0:  next_val = aux_val + index_val; // RULE4
			UPD_SUB0:  next_val = aux_val - index_val; // RULE4
			UPD_BRINC: next_val = br_add; // RULE18
			UPD_BRDEC: next_val = br_sub; // RULE18
			default:   next_val = aux_val;
		endcase
	end

endmodule

`default_nettype wire

/* verilog/operand_address_and_repeat_unit.sv */
// Operand address generation and repeat control of the processor core.
// Assumes the fetch unit offers one instruction word per cycle when ready,
// and that data memory answers a repeat-count read with MEM_RVALID.

`timescale 1ns/1ns
`default_nettype none

module operand_address_and_repeat_unit
	import addr_repeat_pkg::*;
#(
	parameter int MULTI_CYCLES = TABLE_CYCLES,
	parameter int EXT_WAIT     = 1
)(
	input  wire logic              MCLK,
	input  wire logic              RST_N,
	input  wire logic [RADR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	input  wire logic              INS_VALID,
	input  wire logic [DATA_W-1:0] INS_WORD,
	input  wire logic [2:0]        INS_MODE,
	input  wire logic              INS_RPT,
	input  wire logic              INS_MULTI,
	input  wire logic              INS_EXT,
	input  wire logic              MEM_RVALID,
	input  wire logic [DATA_W-1:0] MEM_RDATA,
	output logic                   INS_READY,
	output logic                   FETCH_REQ,
	output logic      [DATA_W-1:0] OPD_ADDR,
	output logic                   OPD_ADDR_VALID,
	output logic      [DATA_W-1:0] OPD_DATA,
	output logic                   OPD_DATA_VALID,
	output logic      [ARP_W-1:0]  OPD_REG,
	output logic                   OPD_REG_VALID,
	output logic                   OPD_REG_IMPL,
	output logic                   EXEC_PULSE,
	output logic                   RPT_ACTIVE,
	output logic                   INT_HOLD
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------

	logic rst_meta_r;
	logic rst_sync_r;
	wire  rst_n = rst_sync_r;

	// Reset asserts at once but leaves on a clock edge, two stages late.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	state_type         state_r;
	state_type         state_nxt;
	logic [PAGE_W-1:0] page_r;
	logic [ARP_W-1:0]  arp_r;
	logic [DATA_W-1:0] aux_r [AUX_N];
	logic [DATA_W-1:0] repeat_counter_r;
	logic [DATA_W-1:0] repeat_counter_nxt;
	logic              armed_r;
	logic              armed_nxt;
	logic              hold_r;
	logic              hold_nxt;
	logic [WAIT_W-1:0] wait_r;
	logic [WAIT_W-1:0] wait_nxt;
	logic [DATA_W-1:0] word_r;
	logic [2:0]        mode_r;
	logic              multi_r;
	logic              ext_r;

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------

	// Used for both the write strobes and the read selection.
	function automatic logic is_aux(input logic [RADR_W-1:0] a);
		return a[AUX_BIT];
	endfunction

	wire             wr_page = REG_WR && (REG_ADDR == REG_PAGE);
	wire             wr_arp  = REG_WR && (REG_ADDR == REG_ARP);
	wire             wr_aux  = REG_WR && is_aux(REG_ADDR);
	wire [ARP_W-1:0] reg_idx = REG_ADDR[ARP_W-1:0];

	wire [ST_BITS-1:0] status_val = {
		state_r == S_BUSY,
		state_r == S_REPEAT,
		hold_r,
		armed_r
	};

	wire [DATA_W-1:0] rd_mux =
		is_aux(REG_ADDR)         ? aux_r[reg_idx] :
		(REG_ADDR == REG_PAGE)   ? {{(DATA_W-PAGE_W){1'b0}}, page_r} :
		(REG_ADDR == REG_ARP)    ? {{(DATA_W-ARP_W){1'b0}}, arp_r} :
		(REG_ADDR == REG_REPEAT_COUNTER)   ? repeat_counter_r :
		(REG_ADDR == REG_STATUS) ? {{(DATA_W-ST_BITS){1'b0}}, status_val} :
		'0;

	// ----------------------------------------------------------------
	// Instruction decode
	// ----------------------------------------------------------------

	// In idle the word on the port is decoded directly; later states work
	// from the copy latched when the word was taken.
	wire        in_idle  = (state_r == S_IDLE);
	wire [15:0] cur_word = in_idle ? INS_WORD : word_r;
	wire [2:0]  cur_mode = in_idle ? INS_MODE : mode_r;
	wire        cur_mult = in_idle ? INS_MULTI : multi_r;
	wire        cur_ext  = in_idle ? INS_EXT : ext_r;

	wire idle_take = INS_VALID && in_idle;
	wire long_done = INS_VALID && (state_r == S_LONG);
	wire take      = idle_take || long_done;
	wire rep_step  = (state_r == S_REPEAT);
	wire is_dir    = (cur_mode == MODE_DIRECT);
	wire is_ind    = (cur_mode == MODE_INDIRECT);
	wire mem_mode  = is_dir || is_ind;

	wire rpt_take  = idle_take && INS_RPT;
	wire rpt_mem   = rpt_take && mem_mode; // RULE9
	wire rpt_short = rpt_take && !mem_mode; // RULE9
	wire long_1st  = idle_take && !INS_RPT && (INS_MODE == MODE_LONG);
	wire start     = (idle_take && !INS_RPT && !long_1st) || long_done;

	// A repeat step reissues the operand access of the repeated word.
	wire addr_evt  = ((idle_take && !long_1st) || rep_step) && mem_mode;
	wire ind_evt   = addr_evt && is_ind;
	wire reg_evt   = idle_take && !INS_RPT &&
		((INS_MODE == MODE_REG) || (INS_MODE == MODE_IMPLIED));

	wire [DATA_W-1:0] short_val =
		{{(DATA_W-SIMM_W){1'b0}}, cur_word[SIMM_MSB:0]}; // RULE6

	// ----------------------------------------------------------------
	// Operand address
	// ----------------------------------------------------------------

	wire [DATA_W-1:0] cur_aux  = aux_r[arp_r]; // RULE3
	wire [DATA_W-1:0] dir_addr = {page_r, cur_word[OFFS_MSB:0]}; // RULE1
	wire [DATA_W-1:0] opd_addr = is_ind ? cur_aux : dir_addr; // RULE2
	wire [DATA_W-1:0] aux_next;
	wire              arp_load = ind_evt && cur_word[ARP_LOAD_BIT];

	aux_update u_aux_update (
		.aux_val   (cur_aux),
		.index_val (aux_r[0]),
		.code      (cur_word[UPD_MSB:UPD_LSB]),
		.next_val  (aux_next)
	);

	// Extra cycles of a single issue: multicycle work plus the stretch of
	// an operand that lives off chip on the shared data bus.
	wire [WAIT_W-1:0] extra =
		(cur_mult ? WAIT_W'(MULTI_CYCLES - 1) : '0) +
		(cur_ext ? WAIT_W'(EXT_WAIT) : '0); // RULE16

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	// Next state, repeat count, arming and interrupt hold.
	always_comb begin
		state_nxt = state_r;
		repeat_counter_nxt  = repeat_counter_r;
		armed_nxt = armed_r;
		hold_nxt  = hold_r;
		wait_nxt  = wait_r;
		case (state_r)
			S_IDLE: begin
				if (rpt_take) begin
					hold_nxt = 1'b1; // RULE12
					if (rpt_mem) begin
						state_nxt = S_RPTLD;
					end else begin
						repeat_counter_nxt  = short_val; // RULE9
						armed_nxt = 1'b1;
					end
				end else if (long_1st) begin
					state_nxt = S_LONG; // RULE7 RULE17
				end
			end
			S_LONG: begin
				state_nxt = S_LONG;
			end
			S_RPTLD: begin
				if (MEM_RVALID) begin
					repeat_counter_nxt  = MEM_RDATA; // RULE9
					armed_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			S_BUSY: begin
				wait_nxt = wait_r - WAIT_W'(1);
				if (wait_r == WAIT_W'(1)) begin
					state_nxt = S_IDLE;
				end
			end
			S_REPEAT: begin
				// One issue per cycle whatever the single-issue cost.
				if (repeat_counter_r == '0) begin
					state_nxt = S_IDLE;
					hold_nxt  = 1'b0; // RULE12
				end else begin
					repeat_counter_nxt = repeat_counter_r - DATA_W'(1); // RULE10 RULE13 RULE14
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
		// First issue of an instruction; an armed repeat makes it the
		// first of N plus one pipelined issues.
		if (start) begin
			if (armed_r) begin
				armed_nxt = 1'b0;
				if (repeat_counter_r == '0) begin
					state_nxt = S_IDLE;
					hold_nxt  = 1'b0; // RULE12
				end else begin
					repeat_counter_nxt  = repeat_counter_r - DATA_W'(1); // RULE10
					state_nxt = S_REPEAT; // RULE13
				end
			end else if (extra != '0) begin
				wait_nxt  = extra; // RULE14 RULE16
				state_nxt = S_BUSY;
			end else begin
				state_nxt = S_IDLE;
			end
		end
	end

	// Sequencer flip-flops; the repeat counter clears on reset.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			repeat_counter_r  <= REPEAT_COUNTER_RST; // RULE11
			armed_r <= 1'b0;
			hold_r  <= 1'b0;
			wait_r  <= '0;
		end else begin
			state_r <= state_nxt;
			repeat_counter_r  <= repeat_counter_nxt;
			armed_r <= armed_nxt;
			hold_r  <= hold_nxt;
			wait_r  <= wait_nxt;
		end
	end

	// Copy of the taken word, kept for long operands and repeat steps.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			word_r  <= '0;
			mode_r  <= MODE_DIRECT;
			multi_r <= 1'b0;
			ext_r   <= 1'b0;
		end else if (idle_take) begin
			word_r  <= INS_WORD;
			mode_r  <= INS_MODE;
			multi_r <= INS_MULTI;
			ext_r   <= INS_EXT;
		end
	end

	// ----------------------------------------------------------------
	// Pointer registers
	// ----------------------------------------------------------------

	// Page pointer and select pointer; an instruction's own pointer load
	// takes precedence over a register port write in the same cycle.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			page_r <= PAGE_RST;
			arp_r  <= ARP_RST;
		end else begin
			if (wr_page) begin
				page_r <= REG_WDATA[PAGE_W-1:0];
			end
			if (arp_load) begin
				arp_r <= cur_word[NEW_ARP_MSB:0]; // RULE5
			end else if (wr_arp) begin
				arp_r <= REG_WDATA[ARP_W-1:0];
			end
		end
	end

	// Auxiliary registers; the current one is updated after its use in
	// the same cycle, ahead of any port write to it.
	genvar gi;
	generate
		for (gi = 0; gi < AUX_N; gi++) begin : g_aux
			wire hw_upd = ind_evt && (arp_r == ARP_W'(gi));
			wire sw_upd = wr_aux && (reg_idx == ARP_W'(gi));
			always_ff @(posedge MCLK or negedge rst_n) begin
				if (!rst_n) begin
					aux_r[gi] <= AUX_RST;
				end else if (hw_upd) begin
					aux_r[gi] <= aux_next; // RULE4 RULE5
				end else if (sw_upd) begin
					aux_r[gi] <= REG_WDATA;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	logic              ready_r;
	logic              fetch_r;
	logic [DATA_W-1:0] oaddr_r;
	logic              oaddr_v_r;
	logic [DATA_W-1:0] odata_r;
	logic              odata_v_r;
	logic [ARP_W-1:0]  oreg_r;
	logic              oreg_v_r;
	logic              oreg_i_r;
	logic              exec_r;
	logic [DATA_W-1:0] rdata_r;

	wire ready_nxt = (state_nxt == S_IDLE) || (state_nxt == S_LONG);

	// Every answer is registered so the core sees clean flop outputs.
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			ready_r   <= 1'b0;
			fetch_r   <= 1'b0;
			oaddr_r   <= '0;
			oaddr_v_r <= 1'b0;
			odata_r   <= '0;
			odata_v_r <= 1'b0;
			oreg_r    <= '0;
			oreg_v_r  <= 1'b0;
			oreg_i_r  <= 1'b0;
			exec_r    <= 1'b0;
			rdata_r   <= '0;
		end else begin
			ready_r   <= ready_nxt;
			fetch_r   <= take; // RULE15
			oaddr_v_r <= addr_evt;
			if (addr_evt) begin
				oaddr_r <= opd_addr; // RULE1 RULE2
			end
			odata_v_r <= (start && (cur_mode == MODE_SHORT)) || long_done;
			if (long_done) begin
				odata_r <= INS_WORD; // RULE7
			end else if (start) begin
				odata_r <= short_val; // RULE6
			end
			oreg_v_r  <= reg_evt; // RULE8
			oreg_i_r  <= reg_evt && (INS_MODE == MODE_IMPLIED); // RULE8
			if (reg_evt) begin
				oreg_r <= INS_WORD[REG_MSB:0];
			end
			exec_r    <= start || rep_step; // RULE13
			rdata_r   <= REG_RD ? rd_mux : '0;
		end
	end

	assign INS_READY      = ready_r;
	assign FETCH_REQ      = fetch_r;
	assign OPD_ADDR       = oaddr_r;
	assign OPD_ADDR_VALID = oaddr_v_r;
	assign OPD_DATA       = odata_r;
	assign OPD_DATA_VALID = odata_v_r;
	assign OPD_REG        = oreg_r;
	assign OPD_REG_VALID  = oreg_v_r;
	assign OPD_REG_IMPL   = oreg_i_r;
	assign EXEC_PULSE     = exec_r;
	assign RPT_ACTIVE     = hold_r;
	assign INT_HOLD       = hold_r;
	assign REG_RDATA      = rdata_r;

endmodule

`default_nettype wire

/* dv/addr_repeat_props.sv */
// Concurrent checks on the ports of the operand address and repeat unit.
// Assumes it is bound to the top module and sees only that module's ports.

`timescale 1ns/1ns
`default_nettype none

module addr_repeat_props
	import addr_repeat_pkg::*;
(
	input wire logic              MCLK,
	input wire logic              RST_N,
	input wire logic [RADR_W-1:0] REG_ADDR,
	input wire logic              REG_RD,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic              INS_VALID,
	input wire logic [DATA_W-1:0] INS_WORD,
	input wire logic [2:0]        INS_MODE,
	input wire logic              INS_RPT,
	input wire logic              INS_READY,
	input wire logic              FETCH_REQ,
	input wire logic [DATA_W-1:0] OPD_ADDR,
	input wire logic              OPD_ADDR_VALID,
	input wire logic [DATA_W-1:0] OPD_DATA,
	input wire logic              OPD_DATA_VALID,
	input wire logic [ARP_W-1:0]  OPD_REG,
	input wire logic              OPD_REG_VALID,
	input wire logic              OPD_REG_IMPL,
	input wire logic              EXEC_PULSE,
	input wire logic              RPT_ACTIVE,
	input wire logic              INT_HOLD
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// A plain take excludes the repeat word, which issues nothing itself.
	wire logic take;
	wire logic take_rpt;
	assign take     = INS_VALID && INS_READY && !INS_RPT;
	assign take_rpt = INS_VALID && INS_READY && INS_RPT;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_fetch_after_take: assert property (INS_VALID && INS_READY |=> FETCH_REQ)
		else $error("no fetch request after a taken word");
	a_direct_addr: assert property (take && INS_MODE == MODE_DIRECT |=>
		EXEC_PULSE && OPD_ADDR_VALID && OPD_ADDR[6:0] == $past(INS_WORD[6:0]))
		else $error("direct address offset wrong");
	a_short_data: assert property (take && INS_MODE == MODE_SHORT |=>
		OPD_DATA_VALID && OPD_DATA[7:0] == $past(INS_WORD[7:0]))
		else $error("short operand field wrong");
	a_reg_field: assert property (take && INS_MODE == MODE_REG |=>
		OPD_REG_VALID && !OPD_REG_IMPL && !OPD_ADDR_VALID
		&& OPD_REG == $past(INS_WORD[2:0]))
		else $error("register operand wrong");
	a_implied_reg: assert property (take && INS_MODE == MODE_IMPLIED |=>
		OPD_REG_IMPL && !OPD_ADDR_VALID)
		else $error("implied register not flagged");
	a_rpt_hold: assert property (take_rpt |=> INT_HOLD && RPT_ACTIVE)
		else $error("interrupts not held after repeat decode");
	a_hold_level: assert property ($fell(INT_HOLD) |-> EXEC_PULSE)
		else $error("hold ended before the last issue");
	a_loop_issue: assert property (EXEC_PULSE && INT_HOLD |=> EXEC_PULSE)
		else $error("repeat loop skipped a cycle");
	a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == '0)
		else $error("read data outside its cycle");
	a_unmapped_rd: assert property (REG_RD && REG_ADDR inside {[4:7]} |=>
		REG_RDATA == '0)
		else $error("unmapped read not zero");

endmodule

bind operand_address_and_repeat_unit addr_repeat_props u_props (
	.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .INS_VALID(INS_VALID), .INS_WORD(INS_WORD),
	.INS_MODE(INS_MODE), .INS_RPT(INS_RPT), .INS_READY(INS_READY),
	.FETCH_REQ(FETCH_REQ), .OPD_ADDR(OPD_ADDR),
	.OPD_ADDR_VALID(OPD_ADDR_VALID), .OPD_DATA(OPD_DATA),
	.OPD_DATA_VALID(OPD_DATA_VALID), .OPD_REG(OPD_REG),
	.OPD_REG_VALID(OPD_REG_VALID), .OPD_REG_IMPL(OPD_REG_IMPL),
	.EXEC_PULSE(EXEC_PULSE), .RPT_ACTIVE(RPT_ACTIVE), .INT_HOLD(INT_HOLD)
);

`default_nettype wire

/* dv/test_operand_address_and_repeat_unit.sv */
// Self-checking bench for the operand address and repeat unit.
// Assumes the default cycle counts; stall expectations come from the bench's own MC and EW.

`timescale 1ns/1ns
`default_nettype none

module test_operand_address_and_repeat_unit
	import addr_repeat_pkg::*;
;
	localparam int MC = 3;
	localparam int EW = 1;

	logic              mclk = 1'b0;
	logic              rst_n = 1'b0;
	logic [RADR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              ins_valid = 1'b0;
	logic [DATA_W-1:0] ins_word = '0;
	logic [2:0]        ins_mode = '0;
	logic              ins_rpt = 1'b0;
	logic              ins_multi = 1'b0;
	logic              ins_ext = 1'b0;
	logic              mem_rvalid = 1'b0;
	logic [DATA_W-1:0] mem_rdata = '0;
	logic [DATA_W-1:0] reg_rdata, opd_addr, opd_data;
	logic [ARP_W-1:0]  opd_reg;
	logic              ins_ready, fetch_req, opd_addr_valid, opd_data_valid;
	logic              opd_reg_valid, opd_reg_impl, exec_pulse;
	logic              rpt_active, int_hold;
	int                fail_count = 0;
	int                cmp_count = 0;
	int                exec_cnt = 0;
	int                cyc = 0;
	logic [DATA_W-1:0] cur;

	operand_address_and_repeat_unit #(.MULTI_CYCLES(MC), .EXT_WAIT(EW)) u_dut (
		.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .INS_VALID(ins_valid), .INS_WORD(ins_word),
		.INS_MODE(ins_mode), .INS_RPT(ins_rpt), .INS_MULTI(ins_multi),
		.INS_EXT(ins_ext), .MEM_RVALID(mem_rvalid), .MEM_RDATA(mem_rdata),
		.INS_READY(ins_ready), .FETCH_REQ(fetch_req), .OPD_ADDR(opd_addr),
		.OPD_ADDR_VALID(opd_addr_valid), .OPD_DATA(opd_data),
		.OPD_DATA_VALID(opd_data_valid), .OPD_REG(opd_reg),
		.OPD_REG_VALID(opd_reg_valid), .OPD_REG_IMPL(opd_reg_impl),
		.EXEC_PULSE(exec_pulse), .RPT_ACTIVE(rpt_active), .INT_HOLD(int_hold)
	);

	// ----------------------------------------------------------------
	// Clock, issue counter and hang guard
	// ----------------------------------------------------------------
	always #2 mclk = ~mclk;

	// Issues are counted on pre-edge values, so no race with the pulse.
	always @(posedge mclk) begin
		cyc++;
		if (exec_pulse === 1'b1)
			exec_cnt++;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks and models
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("TB: compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [RADR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// The read data stand only in the cycle after the read edge.
	task automatic rdc(input logic [RADR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		check(reg_rdata, e);
	endtask

	// Holds the word until an edge sees ready high, then looks mid-cycle.
	task automatic issue(input logic [2:0] m, input logic [DATA_W-1:0] w,
		input logic r, input logic mu, input logic ex);
		@(posedge mclk);
		ins_mode  <= m;
		ins_word  <= w;
		ins_rpt   <= r;
		ins_multi <= mu;
		ins_ext   <= ex;
		ins_valid <= 1'b1;
		do
			@(posedge mclk);
		while (ins_ready !== 1'b1);
		ins_valid <= 1'b0;
		@(negedge mclk);
	endtask

	task automatic stall(input logic mu, input logic ex, input int e);
		int n;
		issue(MODE_DIRECT, 16'h0001, 1'b0, mu, ex);
		n = 0;
		while (ins_ready !== 1'b1 && n < 20) begin
			n++;
			@(negedge mclk);
		end
		check(16'(n), 16'(e));
	endtask

	task automatic repeat_instruction(input logic [7:0] cnt, input logic mu);
		int base;
		issue(MODE_SHORT, {8'h00, cnt}, 1'b1, 1'b0, 1'b0);
		check(16'(int_hold), 16'h0001);
		rdc(REG_STATUS, 16'h0003);
		base = exec_cnt;
		issue(MODE_INDIRECT, 16'h0010, 1'b0, mu, 1'b0);
		repeat (int'(cnt) + 4) @(posedge mclk);
		check(16'(exec_cnt - base), 16'(cnt) + 16'h0001);
		check(16'(int_hold), 16'h0000);
	endtask

	function automatic logic [15:0] mir(input logic [15:0] x);
		for (int i = 0; i < 16; i++)
			mir[i] = x[15-i];
	endfunction

	// Expected pointer after one access with an index of eight.
	function automatic logic [15:0] upd(input logic [15:0] a,
		input logic [2:0] c);
		case (c)
			UPD_INC:   upd = a + 16'h0001;
			UPD_DEC:   upd = a - 16'h0001;
			UPD_ADD0:  upd = a + 16'h0008;
			UPD_SUB0:  upd = a - 16'h0008;
			UPD_BRINC: upd = mir(mir(a) + mir(16'h0008));
			UPD_BRDEC: upd = mir(mir(a) - mir(16'h0008));
			default:   upd = a;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check(16'(ins_ready), 16'h0000);
		@(negedge mclk);
		check(16'(ins_ready), 16'h0001);
		rdc(REG_REPEAT_COUNTER, REPEAT_COUNTER_RST);
		rdc(REG_ARP, 16'h0000);
		wr(REG_REPEAT_COUNTER, 16'h00ff);
		rdc(REG_REPEAT_COUNTER, REPEAT_COUNTER_RST);
		rdc(4'h5, 16'h0000);
		wr(REG_PAGE, 16'h01a5);
		issue(MODE_DIRECT, 16'h00d5, 1'b0, 1'b0, 1'b0);
		check(opd_addr, {9'h1a5, 7'h55});
		check(16'(fetch_req), 16'h0001);
		issue(MODE_SHORT, 16'h12c3, 1'b0, 1'b0, 1'b0);
		check(16'(opd_data[7:0]), 16'h00c3);
		issue(MODE_LONG, 16'h0000, 1'b0, 1'b0, 1'b0);
		check(16'(exec_pulse), 16'h0000);
		issue(MODE_LONG, 16'hbeef, 1'b0, 1'b0, 1'b0);
		check(opd_data, 16'hbeef);
		check(16'(exec_pulse), 16'h0001);
		issue(MODE_REG, 16'h0006, 1'b0, 1'b0, 1'b0);
		check(16'(opd_reg), 16'h0006);
		issue(MODE_IMPLIED, 16'h0000, 1'b0, 1'b0, 1'b0);
		check(16'(opd_reg_impl), 16'h0001);
		wr(4'h8, 16'h0008);
		wr(4'ha, 16'h0100);
		wr(REG_ARP, 16'h0002);
		cur = 16'h0100;
		for (int c = 0; c < 8; c++) begin
			issue(MODE_INDIRECT, {9'h000, 3'(c), 4'h0}, 1'b0, 1'b0, 1'b0);
			check(opd_addr, cur);
			cur = upd(cur, 3'(c));
			rdc(4'ha, cur);
		end
		issue(MODE_INDIRECT, 16'h000d, 1'b0, 1'b0, 1'b0);
		check(opd_addr, cur);
		rdc(REG_ARP, 16'h0005);
		wr(4'hd, 16'h4321);
		issue(MODE_INDIRECT, 16'h0010, 1'b0, 1'b0, 1'b0);
		check(opd_addr, 16'h4321);
		rdc(4'hd, 16'h4322);
		stall(1'b0, 1'b0, 0);
		stall(1'b1, 1'b0, MC - 1);
		stall(1'b1, 1'b1, MC - 1 + EW);
		repeat_instruction(8'h02, 1'b0);
		repeat_instruction(8'h00, 1'b0);
		repeat_instruction(8'h03, 1'b1);
		rdc(4'hd, 16'h432a);
		// Count from memory: the unit waits for the data answer.
		issue(MODE_DIRECT, 16'h0010, 1'b1, 1'b0, 1'b0);
		check(opd_addr, {9'h1a5, 7'h10});
		repeat (3) @(posedge mclk);
		check(16'(ins_ready), 16'h0000);
		mem_rdata  <= 16'h0001;
		mem_rvalid <= 1'b1;
		@(posedge mclk);
		mem_rvalid <= 1'b0;
		cur = 16'(exec_cnt);
		issue(MODE_DIRECT, 16'h0002, 1'b0, 1'b1, 1'b0);
		repeat (6) @(posedge mclk);
		check(16'(exec_cnt) - cur, 16'h0002);
		end_of_test();
	end

endmodule

`default_nettype wire
